// [verilog/feram_block_access_control.sv]
// Per-block access permission and system area config decode
`timescale 1ns/1ps
`include "feram_access_cfg.svh"
// Functional notes
// - Memory is 32 blocks of 16 bytes; block starts at sixteen times its number.
// - Blocks 0-26 are user area; blocks 27-31 from 0x1B0 are system area.
// - Config fields are always fetched from fixed physical byte addresses.
// - RF lock and protect bits combine into plaintext and encrypted permissions.
// - RF protect map applies only to RF commands, never to serial ones.
// - RF protect map is bytes 0x1F0-0x1F3, bit n is block 8*byte+n.
// - Serial protect bit 0 allows read and write; 1 allows read only.
// - Serial protect map is bytes 0x1F4-0x1F7 with the same mapping.
// - Plaintext lock map is bytes 0x1F8-0x1FB with the same mapping.
// - Lock map is ignored for anything but RF memory commands.
// - All three maps start at zero, so every user block is open.
// - Protocol select is config bits 5:4, identifier source bit 0.
// - Serial target address is bits 6:0 of byte 0x1EF.
// - Identifier source bit picks fixed or stored identifier data.
// - RF parameters and access data live in system area and are consulted.
// - Protocol field: 00 auto, 01 first only, 10 type B only, 11 as 00.
// - Identifier source 0 presents zeros; 1 presents stored bytes.
// - Default serial target address is 1010100.
module feram_block_access_control #(
	parameter int USER_BLOCKS = `USER_BLOCKS,
	parameter int ID_BITS = 64
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command from the RF or serial command processor
	input wire feram_access_pkg::access_req_s req,
	// Verdict and memory strobes, one cycle later
	output feram_access_pkg::access_resp_s resp,
	// Identifier bytes read from the system area
	input wire logic [ID_BITS-1:0] stored_identifier,
	// Decoded configuration
	output logic [ID_BITS-1:0] card_identifier,
	output feram_access_pkg::rf_protocol_e rf_protocol_select,
	output logic identifier_source_select,
	output logic [6:0] serial_target_address
);

	// ****************************************
	// Shadow copies of the system area
	// ****************************************

	logic [15:0] hw_cfg_reg;
	logic [31:0] rf_map_reg;
	logic [31:0] ser_map_reg;
	logic [31:0] lock_map_reg;
	wire [15:0] hw_cfg_next;
	wire [31:0] rf_map_next;
	wire [31:0] ser_map_next;
	wire [31:0] lock_map_next;

	// Output registers
	feram_access_pkg::access_resp_s resp_reg;
	wire feram_access_pkg::access_resp_s resp_next;
	feram_access_pkg::rf_protocol_e proto_reg;
	feram_access_pkg::rf_protocol_e proto_next;
	logic id_src_reg;
	logic [6:0] target_reg;
	logic [ID_BITS-1:0] ident_reg;

	// ****************************************
	// Address decode
	// ****************************************

	// Block bit of a map; reserved and system blocks read as clear
	// Reserved bits never consulted
	function automatic logic map_bit(input logic [31:0] map, input logic [4:0] blk);
		map_bit = (blk < 5'(USER_BLOCKS)) ? map[blk] : 1'b0;
	endfunction

	// Block number is the address over sixteen
	wire [4:0] blk = req.addr[8:4];
	// System area starts at its fixed base
	wire sys_area = req.addr >= `SYS_AREA_BASE;
	wire is_rf = req.source == feram_access_pkg::SRC_RF;
	wire plain = ~req.encrypted;

	// RF protect bit of the addressed block
	wire wp_bit = map_bit(rf_map_reg, blk);
	// Plaintext lock bit of the addressed block
	wire lock_bit = map_bit(lock_map_reg, blk);
	// Serial protect bit of the addressed block
	wire ser_bit = map_bit(ser_map_reg, blk);

	// ****************************************
	// Permission decode
	// ****************************************

	// Plaintext refused only with protect set and lock clear
	wire rf_rd_ok = ~(plain & wp_bit & ~lock_bit);
	// Lock alone forbids writes; encrypted overrides lock with protect
	wire rf_wr_ok = plain ? (~wp_bit & ~lock_bit) : ~(lock_bit & ~wp_bit);
	// Serial path: reads always, writes when protect bit clear
	wire ser_wr_ok = ~ser_bit;
	// RF maps steer only RF commands
	// Lock map unused on serial path
	wire wr_ok = is_rf ? rf_wr_ok : ser_wr_ok;
	wire rd_ok = is_rf ? rf_rd_ok : 1'b1;
	// Verdict consults the system area shadows
	wire allowed = sys_area | (req.write ? wr_ok : rd_ok);
	wire granted_wr = req.valid & allowed & req.write;

	// Response assembly
	// Refused access drops strobes and flags an error
	assign resp_next.done = req.valid;
	assign resp_next.granted = req.valid & allowed;
	assign resp_next.access_error = req.valid & ~allowed;
	assign resp_next.mem_write = granted_wr;
	assign resp_next.mem_read = req.valid & allowed & ~req.write;
	assign resp_next.addr = req.addr;
	assign resp_next.wdata = req.wdata;

	// ****************************************
	// Shadow update from granted writes
	// ****************************************

	// Each shadow byte snoops its fixed physical address
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_map_byte
			wire rf_hit = granted_wr && req.addr == 9'(`RF_MAP_ADDR + i);
			wire ser_hit = granted_wr && req.addr == 9'(`SER_MAP_ADDR + i);
			wire lock_hit = granted_wr && req.addr == 9'(`LOCK_MAP_ADDR + i);
			assign rf_map_next[8*i+:8] = rf_hit ? req.wdata : rf_map_reg[8*i+:8];
			assign ser_map_next[8*i+:8] = ser_hit ? req.wdata : ser_map_reg[8*i+:8];
			assign lock_map_next[8*i+:8] = lock_hit ? req.wdata : lock_map_reg[8*i+:8];
			if (i < 2) begin : g_cfg_byte
				wire cfg_hit = granted_wr && req.addr == 9'(`HW_CFG_ADDR + i);
				assign hw_cfg_next[8*i+:8] = cfg_hit ? req.wdata : hw_cfg_reg[8*i+:8];
			end
		end
	endgenerate

	// ****************************************
	// Configuration decode
	// ****************************************

	// Protocol field sits at bits 5:4
	wire [1:0] proto_field = hw_cfg_next[`PROTO_LSB+:2];
	// Reserved code falls back to automatic detection
	always_comb begin
		case (proto_field)
			2'h1: proto_next = feram_access_pkg::PROTO_FIRST_ONLY;
			2'h2: proto_next = feram_access_pkg::PROTO_TYPE_B_ONLY;
			default: proto_next = feram_access_pkg::PROTO_AUTO;
		endcase
	end

	wire id_src_next = hw_cfg_next[`ID_SRC_BIT];
	// Target address from bits 6:0 of the upper byte
	wire [6:0] target_next = hw_cfg_next[`TARGET_LSB+:7];
	wire [ID_BITS-1:0] ident_next = id_src_next ? stored_identifier : '0;

	// ****************************************
	// Registers
	// ****************************************

	// Shadows; maps reset to zero
	// Config reset carries the default target address
	always_ff @(posedge clk) begin
		if (rst) begin
			hw_cfg_reg <= `HW_CFG_RESET;
			rf_map_reg <= `MAP_RESET;
			ser_map_reg <= `MAP_RESET;
			lock_map_reg <= `MAP_RESET;
		end else begin
			hw_cfg_reg <= hw_cfg_next;
			rf_map_reg <= rf_map_next;
			ser_map_reg <= ser_map_next;
			lock_map_reg <= lock_map_next;
		end
	end

	// Verdict and decoded configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			resp_reg <= '0;
			proto_reg <= feram_access_pkg::PROTO_AUTO;
			id_src_reg <= 1'b0;
			target_reg <= 7'(`HW_CFG_RESET >> `TARGET_LSB);
			ident_reg <= '0;
		end else begin
			resp_reg <= resp_next;
			proto_reg <= proto_next;
			id_src_reg <= id_src_next;
			target_reg <= target_next;
			ident_reg <= ident_next;
		end
	end

	// Outputs straight from flip-flops
	assign resp = resp_reg;
	assign rf_protocol_select = proto_reg;
	assign identifier_source_select = id_src_reg;
	assign serial_target_address = target_reg;
	assign card_identifier = ident_reg;

	// ****************************************
	// Checks
	// ****************************************

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_plain_wp_refuse: assert property (
		req.valid && is_rf && !req.encrypted && req.addr < `SYS_AREA_BASE
		&& rf_map_reg[req.addr[8:4]] && !lock_map_reg[req.addr[8:4]]
		|=> resp.access_error && !resp.mem_read && !resp.mem_write)
		else $error("plaintext access to protected block not refused");

	a_lock_no_write: assert property (
		req.valid && is_rf && req.write && req.addr < `SYS_AREA_BASE
		&& lock_map_reg[req.addr[8:4]] && !rf_map_reg[req.addr[8:4]]
		|=> resp.access_error && !resp.mem_write)
		else $error("write to locked block not refused");

	// Encrypted write to protected block passes
	a_enc_wp_write: assert property (
		req.valid && is_rf && req.encrypted && req.write
		&& req.addr < `SYS_AREA_BASE && rf_map_reg[req.addr[8:4]]
		|=> resp.granted && resp.mem_write)
		else $error("encrypted write to protected block refused");

	// Serial read only when protect bit set
	a_serial_ro: assert property (
		req.valid && !is_rf && req.addr < `SYS_AREA_BASE
		&& ser_map_reg[req.addr[8:4]]
		|=> resp.access_error == $past(req.write))
		else $error("serial protect bit misapplied");

	a_serial_free: assert property (
		req.valid && !is_rf && !ser_map_reg[req.addr[8:4]]
		|=> resp.granted)
		else $error("serial access refused by RF maps");

	a_error_quiet: assert property (
		resp.access_error |-> !resp.mem_write && !resp.mem_read && resp.done)
		else $error("refused access still strobed memory");

	// Verdict one cycle after the request
	a_done_latency: assert property (
		resp.done == $past(req.valid))
		else $error("verdict not one cycle after request");

	// Granted write lands in the RF map byte
	a_map_update: assert property (
		req.valid && req.write && req.addr == `RF_MAP_ADDR
		|=> rf_map_reg[7:0] == $past(req.wdata))
		else $error("RF map byte not updated");

	// Reserved protocol code reads as automatic
	a_proto_reserved: assert property (
		hw_cfg_reg[5:4] == 2'h3 |-> rf_protocol_select == feram_access_pkg::PROTO_AUTO)
		else $error("reserved protocol code not defaulted");

	a_ident_zero: assert property (
		!identifier_source_select |-> card_identifier == '0)
		else $error("identifier not zero with fixed source");

	// Target address follows the config byte
	a_target_field: assert property (
		serial_target_address == hw_cfg_reg[14:8])
		else $error("target address differs from config");

	// Lock alone still lets plaintext read
	a_lock_plain_read: assert property (
		req.valid && is_rf && !req.encrypted && !req.write && req.addr < `SYS_AREA_BASE
		&& lock_map_reg[req.addr[8:4]] |=> resp.granted && resp.mem_read)
		else $error("plaintext read of locked block refused");

	// Block with both RF bits clear is open
	a_open_block: assert property (
		req.valid && is_rf && req.addr < `SYS_AREA_BASE && !rf_map_reg[req.addr[8:4]]
		&& !lock_map_reg[req.addr[8:4]] |=> resp.granted)
		else $error("open block refused");

	a_enc_read_free: assert property (
		req.valid && is_rf && req.encrypted && !req.write
		|=> resp.granted && resp.mem_read)
		else $error("encrypted read refused");

	a_serial_read_free: assert property (
		req.valid && !is_rf && !req.write
		|=> resp.granted && resp.mem_read)
		else $error("serial read refused");

	a_sys_area_open: assert property (
		req.valid && req.addr >= `SYS_AREA_BASE
		|=> resp.granted && !resp.access_error)
		else $error("system area access refused");

	// A read never strobes a memory write
	a_read_no_write: assert property (
		req.valid && !req.write
		|=> !resp.mem_write)
		else $error("read raised the write strobe");

	a_idle_quiet: assert property (
		!req.valid
		|=> !resp.done && !resp.granted && !resp.access_error && !resp.mem_write && !resp.mem_read)
		else $error("verdict strobe without a request");

	// Address and data reach memory one cycle later
	a_copy_follow: assert property (
		!$past(rst)
		|-> resp.addr == $past(req.addr) && resp.wdata == $past(req.wdata))
		else $error("address or data copy lags the request");

	// Granted write lands in the lock map byte
	a_lock_map_update: assert property (
		req.valid && req.write && req.addr == `LOCK_MAP_ADDR
		|=> lock_map_reg[7:0] == $past(req.wdata))
		else $error("lock map byte not updated");

	// Granted write lands in the serial map byte
	a_ser_map_update: assert property (
		req.valid && req.write && req.addr == `SER_MAP_ADDR
		|=> ser_map_reg[7:0] == $past(req.wdata))
		else $error("serial map byte not updated");

	// Identifier source follows bit 0 of the config byte
	a_cfg_update: assert property (
		req.valid && req.write && req.addr == `HW_CFG_ADDR
		|=> identifier_source_select == $past(req.wdata[0]))
		else $error("identifier source not taken from config");

	// Code 01 selects the first protocol only
	a_proto_first: assert property (
		hw_cfg_reg[5:4] == 2'h1 |-> rf_protocol_select == feram_access_pkg::PROTO_FIRST_ONLY)
		else $error("protocol code 01 not decoded");

endmodule

// [common/feram_access_cfg.svh]
// Offsets, field positions, reset values for the block access control
`ifndef FERAM_ACCESS_CFG_SVH
`define FERAM_ACCESS_CFG_SVH
`define BLOCK_COUNT 32
`define BLOCK_BYTES 16
`define USER_BLOCKS 27
`define SYS_AREA_BASE 9'h1B0
`define HW_CFG_ADDR 9'h1EE
`define RF_MAP_ADDR 9'h1F0
`define SER_MAP_ADDR 9'h1F4
`define LOCK_MAP_ADDR 9'h1F8
`define PROTO_LSB 4
`define ID_SRC_BIT 0
`define TARGET_LSB 8
`define HW_CFG_RESET 16'h5400
`define MAP_RESET 32'h00000000
`endif

// [common/feram_access_pkg.sv]
// Types shared by the block access control and its users
package feram_access_pkg;
	typedef enum logic {SRC_RF, SRC_SERIAL} access_source_e;
	typedef enum logic [1:0] {PROTO_AUTO, PROTO_FIRST_ONLY, PROTO_TYPE_B_ONLY} rf_protocol_e;
	typedef struct packed {
		logic valid;
		access_source_e source;
		logic encrypted;
		logic write;
		logic [8:0] addr;
		logic [7:0] wdata;
	} access_req_s;
	typedef struct packed {
		logic done;
		logic granted;
		logic access_error;
		logic mem_write;
		logic mem_read;
		logic [8:0] addr;
		logic [7:0] wdata;
	} access_resp_s;
endpackage

// [testbench/feram_mem_model.sv]
// Behavioural memory array that sits behind the access control
`timescale 1ns/1ps
module feram_mem_model (
	// Clock
	input wire logic clk,
	// Verdict and strobes from the access control
	input wire feram_access_pkg::access_resp_s resp
);
	logic [7:0] mem [0:511];

	// Seed every byte with a pattern so that a stray write shows up
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = 8'h5A ^ i[7:0];
		end
	end

	// Store only on a granted write strobe
	always @(posedge clk) begin
		if (resp.mem_write) begin
			mem[resp.addr] <= resp.wdata;
		end
	end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the block access control
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	feram_access_pkg::access_req_s req = '0;
	feram_access_pkg::access_resp_s resp;
	logic [63:0] stored_id = 64'h0123456789ABCDEF;
	logic [63:0] card_id;
	feram_access_pkg::rf_protocol_e proto;
	logic id_src;
	logic [6:0] target;
	logic [7:0] sh [0:11];
	int num_errors = 0;
	int comparisons = 0;
	logic [8:0] addrs [0:6] = '{9'h000, 9'h013, 9'h02F, 9'h030, 9'h10A, 9'h1A5, 9'h1B0};
	logic [8:0] sa [0:4] = '{9'h1F0, 9'h1F8, 9'h1F3, 9'h1F6, 9'h1F4};
	logic [7:0] sv [0:4] = '{8'h06, 8'h05, 8'h04, 8'h01, 8'h08};

	// Clock, 10 ns period
	always #5 clk = ~clk;

	feram_block_access_control dut (.clk(clk), .rst(rst), .req(req), .resp(resp),
		.stored_identifier(stored_id), .card_identifier(card_id), .rf_protocol_select(proto),
		.identifier_source_select(id_src), .serial_target_address(target));
	feram_mem_model mem_model (.clk(clk), .resp(resp));

	// Compare and count
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	// Expected permission from the shadow copy of the three maps
	function automatic logic allow(logic s, logic enc, logic wr, logic [8:0] a);
		logic [4:0] b;
		logic w, l, sp;
		b = a[8:4];
		if (b > 5'h1A) return 1'b1;
		w = sh[b[4:3]][b[2:0]];
		sp = sh[4 + b[4:3]][b[2:0]];
		l = sh[8 + b[4:3]][b[2:0]];
		if (s) return !(wr && sp);
		if (!enc && w && !l) return 1'b0;
		if (l && (!enc || !w)) return !wr;
		return 1'b1;
	endfunction

	// One command, its verdict and its effect on the memory
	task acc(input logic s, input logic enc, input logic wr, input logic [8:0] a, input logic [7:0] d);
		logic ok;
		logic [7:0] prev;
		ok = allow(s, enc, wr, a);
		prev = mem_model.mem[a];
		@(posedge clk);
		req <= '{valid: 1'b1, source: feram_access_pkg::access_source_e'(s), encrypted: enc,
			write: wr, addr: a, wdata: d};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		chk("done", 1'b1, resp.done);
		chk("granted", ok, resp.granted);
		chk("access_error", !ok, resp.access_error);
		chk("mem_write", ok && wr, resp.mem_write);
		chk("mem_read", ok && !wr, resp.mem_read);
		chk("resp_addr", a, resp.addr);
		chk("resp_wdata", d, resp.wdata);
		if (ok && wr && a >= 9'h1F0 && a <= 9'h1FB) sh[a - 9'h1F0] = d;
		@(posedge clk);
		#1;
		chk("memory", (wr && ok) ? d : prev, mem_model.mem[a]);
	endtask

	// Every source, form and direction on every sample address
	task run_all;
		for (int i = 0; i < 7; i++) begin
			for (int k = 0; k < 8; k++) begin
				acc(k[2], k[1], k[0], addrs[i], {i[3:0], k[3:0]});
			end
		end
	endtask

	// Write the low config byte and check the decoded fields
	task cfg(input logic [7:0] v);
		acc(1'b0, 1'b0, 1'b1, 9'h1EE, v);
		chk("protocol", (v[5:4] == 2'h3) ? 2'h0 : v[5:4], proto);
		chk("id_source", v[0], id_src);
		chk("card_identifier", v[0] ? stored_id : 64'h0, card_id);
	endtask

	task final_report;
		$display("num_errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report;
	end

	// Main sequence
	initial begin
		for (int i = 0; i < 12; i++) begin
			sh[i] = 8'h00;
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("resp_reset", 64'h0, resp);
		chk("protocol_reset", 64'h0, proto);
		chk("id_source_reset", 64'h0, id_src);
		chk("target_reset", 7'h54, target);
		chk("card_identifier_reset", 64'h0, card_id);
		run_all;
		for (int i = 0; i < 5; i++) begin
			acc(1'b0, 1'b0, 1'b1, sa[i], sv[i]);
		end
		run_all;
		cfg(8'h31);
		cfg(8'h20);
		cfg(8'h10);
		cfg(8'h00);
		acc(1'b1, 1'b0, 1'b1, 9'h1EF, 8'hAA);
		chk("target", 7'h2A, target);
		final_report;
	end
endmodule
